// ---- logic/vcr_cfg.svh ----
// Purpose: Constants for the channel resource 0 register bank
// Assumes: Included by bare name from the package and the design
// Notes:   Offsets are byte addresses on the register bus
`ifndef VCR_CFG_SVH
`define VCR_CFG_SVH

`define VCR_ADDR_W            12
`define VCR_OFF_CAP           12'h210
`define VCR_OFF_CTL           12'h214
`define VCR_OFF_STS           12'h218

// Capability word fields
`define VCR_ARB_CAP_LSB       0
`define VCR_ARB_CAP_MSB       7
`define VCR_ARB_CAP_VAL       8'h01
`define VCR_SNOOP_REJ_BIT     15
`define VCR_MAX_TS_LSB        16
`define VCR_MAX_TS_MSB        22
`define VCR_MAX_TS_VAL        7'h00
`define VCR_ARB_TOFF_LSB      24
`define VCR_ARB_TOFF_MSB      31
`define VCR_ARB_TOFF_VAL      8'h00

// Capability scheme bit positions
`define VCR_SCH_HW_FIXED      0
`define VCR_SCH_WRR32         1
`define VCR_SCH_WRR64         2
`define VCR_SCH_WRR128        3
`define VCR_SCH_TWRR128       4

// Control word fields
`define VCR_TC_MAP_LSB        0
`define VCR_TC_MAP_MSB        7
`define VCR_TC_MAP_RST        8'hff
`define VCR_TC_MAP_WMASK      8'hfe
`define VCR_LOAD_TBL_BIT      16
`define VCR_ARB_SEL_LSB       17
`define VCR_ARB_SEL_MSB       19
`define VCR_ARB_SEL_RST       3'h0
`define VCR_CHAN_ID_LSB       24
`define VCR_CHAN_ID_MSB       26
`define VCR_CHAN_ID_VAL       3'h0
`define VCR_CHAN_EN_BIT       31

// Status word fields
`define VCR_TBL_STS_BIT       16
`define VCR_NEG_PEND_BIT      17

`endif

// ---- logic/vcr_pkg.sv ----
// Purpose: Types shared by the channel resource 0 register bank
// Assumes: vcr_cfg.svh holds the numbers
// Notes:   Arbitration select encodings
`default_nettype none
`include "vcr_cfg.svh"
package vcr_pkg;
  typedef enum logic [2:0] {
    VCR_ARB_HW_FIXED = 3'h0
  } vcr_arb_sel_t;

  typedef enum logic [1:0] {
    VCR_ST_IDLE = 2'b01,
    VCR_ST_ACK  = 2'b10
  } vcr_bus_state_t;
endpackage : vcr_pkg
`default_nettype wire

// ---- logic/vcr_regs.sv ----
// Purpose: Channel resource 0 capability, control and status words
// Assumes: Classic Wishbone slave, one aligned 32-bit word per register
// Notes:   Ack one cycle after the request; unmapped reads return zero
//
// Functional notes
// - Arbitration capability field reads one: hardware fixed round-robin only
// - Capability bits: fixed, WRR 32/64/128, time-based WRR 128; 5-7 reserved
// - Snoop reject bit reads zero
// - Maximum time slots field reads zero
// - Arbitration table offset field reads zero
// - Each traffic class map bit marks one class carried on this channel
// - Traffic class map resets to all ones; bit 0 read-only, 1-7 writable
// - Load arbitration table bit reads zero
// - Arbitration select writable, resets zero; zero means fixed round-robin
// - Channel identifier hardwired to zero
// - Channel enable hardwired to one
// - Arbitration table status reads zero
// - Negotiation pending reads zero
//
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "vcr_cfg.svh"

module vcr_regs (
  input  wire logic                    i_clock,
  input  wire logic                    i_resetn,
  input  wire logic                    i_clk_en,
  input  wire logic                    i_wb_cyc,
  input  wire logic                    i_wb_stb,
  input  wire logic                    i_wb_we,
  input  wire logic [`VCR_ADDR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]              i_wb_sel,
  input  wire logic [31:0]             i_wb_dat,
  output logic      [31:0]             o_wb_dat,
  output logic                         o_wb_ack,
  output logic      [7:0]              o_traffic_class_map,
  output logic      [2:0]              o_arb_select,
  output logic                         o_arb_select_valid
);

  // Register state
  vcr_pkg::vcr_bus_state_t state;
  vcr_pkg::vcr_bus_state_t next_state;
  logic [7:0]  tc_map;
  logic [7:0]  next_tc_map;
  logic [2:0]  arb_sel;
  logic [2:0]  next_arb_sel;
  logic [31:0] next_rdata;
  logic        req;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic [31:0] sts_word;
  logic [31:0] wmask;
  logic        next_ack;
  logic        next_valid;

  // Expand byte enables into a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : sel_mask

  // Advertised schemes; only hardware fixed is set
  function automatic logic scheme_supported(input logic [2:0] s);
    return (s == vcr_pkg::VCR_ARB_HW_FIXED);
  endfunction : scheme_supported

  assign req   = i_wb_cyc & i_wb_stb & (state == vcr_pkg::VCR_ST_IDLE);
  assign wmask = sel_mask(i_wb_sel);

  // Read views; unassigned bits are reserved zero
  always_comb begin
    cap_word = 32'h0;
    cap_word[`VCR_ARB_CAP_MSB:`VCR_ARB_CAP_LSB] = `VCR_ARB_CAP_VAL;
    cap_word[`VCR_SCH_HW_FIXED] = 1'b1;
    cap_word[`VCR_SNOOP_REJ_BIT] = 1'b0;
    cap_word[`VCR_MAX_TS_MSB:`VCR_MAX_TS_LSB] = `VCR_MAX_TS_VAL;
    cap_word[`VCR_ARB_TOFF_MSB:`VCR_ARB_TOFF_LSB] = `VCR_ARB_TOFF_VAL;
    ctl_word = 32'h0;
    ctl_word[`VCR_TC_MAP_MSB:`VCR_TC_MAP_LSB] = tc_map;
    ctl_word[`VCR_LOAD_TBL_BIT] = 1'b0;
    ctl_word[`VCR_ARB_SEL_MSB:`VCR_ARB_SEL_LSB] = arb_sel;
    ctl_word[`VCR_CHAN_ID_MSB:`VCR_CHAN_ID_LSB] = `VCR_CHAN_ID_VAL;
    ctl_word[`VCR_CHAN_EN_BIT] = 1'b1;
    sts_word = 32'h0;
    sts_word[`VCR_TBL_STS_BIT] = 1'b0;
    sts_word[`VCR_NEG_PEND_BIT] = 1'b0;
  end

  // Next values: writes only touch the writable control fields
  always_comb begin
    next_state  = state;
    next_tc_map = tc_map;
    next_arb_sel = arb_sel;
    next_rdata  = o_wb_dat;
    case (state)
      vcr_pkg::VCR_ST_IDLE: begin
        if (req) begin
          next_state = vcr_pkg::VCR_ST_ACK;
          next_rdata = 32'h0;
          if (i_wb_we) begin
            if (i_wb_adr == `VCR_OFF_CTL) begin
              // Bit 0 kept set: class 0 always rides this channel
              next_tc_map = (tc_map & ~(`VCR_TC_MAP_WMASK & wmask[7:0]))
                          | (i_wb_dat[7:0] & `VCR_TC_MAP_WMASK & wmask[7:0]);
              if (wmask[`VCR_ARB_SEL_LSB]) begin
                next_arb_sel = i_wb_dat[`VCR_ARB_SEL_MSB:`VCR_ARB_SEL_LSB];
              end
            end
          end else if (i_wb_adr == `VCR_OFF_CAP) begin
            next_rdata = cap_word;
          end else if (i_wb_adr == `VCR_OFF_CTL) begin
            next_rdata = ctl_word;
          end else if (i_wb_adr == `VCR_OFF_STS) begin
            next_rdata = sts_word;
          end else begin
            next_rdata = 32'h0;
          end
        end
      end
      vcr_pkg::VCR_ST_ACK: begin
        next_state = vcr_pkg::VCR_ST_IDLE;
      end
      default: begin
        next_state = vcr_pkg::VCR_ST_IDLE;
      end
    endcase
    // Ack and validity derive from the chosen next values
    next_ack   = (next_state == vcr_pkg::VCR_ST_ACK);
    next_valid = scheme_supported(next_arb_sel);
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state               <= vcr_pkg::VCR_ST_IDLE;
      tc_map              <= `VCR_TC_MAP_RST;
      arb_sel             <= `VCR_ARB_SEL_RST;
      o_wb_dat            <= 32'h0;
      o_wb_ack            <= 1'b0;
      o_traffic_class_map <= `VCR_TC_MAP_RST;
      o_arb_select        <= `VCR_ARB_SEL_RST;
      o_arb_select_valid  <= 1'b1;
    end else if (i_clk_en) begin
      state               <= next_state;
      tc_map              <= next_tc_map;
      arb_sel             <= next_arb_sel;
      o_wb_dat            <= next_rdata;
      o_wb_ack            <= next_ack;
      o_traffic_class_map <= next_tc_map;
      o_arb_select        <= next_arb_sel;
      // Undefined scheme flagged for the arbiter; software must avoid it
      o_arb_select_valid  <= next_valid;
    end
  end

  // Checks on the bus handshake
  // Ack is a single pulse while the enable runs
  a_ack_one_cycle: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_wb_ack && i_clk_en |=> !o_wb_ack) else $error("ack held two cycles");

  // Every taken request is answered on the next edge
  a_ack_follows_req: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req |=> o_wb_ack) else $error("request not acked");

  // No ack appears without a taken request behind it
  a_ack_needs_req: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(o_wb_ack) |-> $past(req && i_clk_en)) else $error("ack without request");

  // Enable low holds everything; a stalled master simply waits longer
  a_enable_freeze: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !i_clk_en |=> $stable(o_wb_ack) && $stable(tc_map) && $stable(arb_sel))
    else $error("state moved while frozen");

  // Writes answer with zero data, so a master may ignore it
  a_write_data_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && i_wb_we |=> o_wb_dat == 32'h0) else $error("write returned data");

  // Synchronous reset wins over a low clock enable
  a_reset_defaults: assert property (@(posedge i_clock)
    !i_resetn |=> o_traffic_class_map == `VCR_TC_MAP_RST
    && o_arb_select == `VCR_ARB_SEL_RST && o_arb_select_valid && !o_wb_ack)
    else $error("reset defaults wrong");

  // Capability word: one fixed value, hardware fixed scheme only
  a_cap_read_val: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_CAP
    |=> o_wb_dat == 32'h0000_0001) else $error("capability word wrong");

  // Scheme bits other than hardware fixed stay clear
  a_scheme_bits: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_CAP
    |=> o_wb_dat[`VCR_SCH_HW_FIXED] && o_wb_dat[`VCR_SCH_TWRR128:`VCR_SCH_WRR32] == 4'h0)
    else $error("scheme bits wrong");

  // Snoop rejection is not offered by a switch port
  a_snoop_reject_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_CAP
    |=> !o_wb_dat[`VCR_SNOOP_REJ_BIT]) else $error("snoop reject set");

  // Time slot count has no meaning without time-based arbitration
  a_time_slots_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_CAP
    |=> o_wb_dat[`VCR_MAX_TS_MSB:`VCR_MAX_TS_LSB] == `VCR_MAX_TS_VAL)
    else $error("time slot field not zero");

  // No arbitration table, so no offset to one
  a_table_offset_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_CAP
    |=> o_wb_dat[`VCR_ARB_TOFF_MSB:`VCR_ARB_TOFF_LSB] == `VCR_ARB_TOFF_VAL)
    else $error("table offset not zero");

  // Control word: class 0 never leaves this channel
  a_tc_bit0_set: assert property (@(posedge i_clock) disable iff (!i_resetn)
    tc_map[0]) else $error("class 0 map bit cleared");

  // Enable set, identifier and reserved bits clear
  a_ctl_read_fix: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_CTL
    |=> o_wb_dat[31:20] == 12'h800 && o_wb_dat[16:8] == 9'h0)
    else $error("control fixed fields wrong");

  // Table load bit reads zero, there is nothing to load
  a_load_bit_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_CTL
    |=> !o_wb_dat[`VCR_LOAD_TBL_BIT]) else $error("load table bit set");

  // Control reads show the stored map and select
  a_ctl_read_live: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_CTL
    |=> o_wb_dat[7:0] == $past(tc_map) && o_wb_dat[19:17] == $past(arb_sel))
    else $error("control read not live");

  // Select field follows the data on its own byte lane
  a_sel_write: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && i_wb_we && i_wb_adr == `VCR_OFF_CTL && i_wb_sel[2]
    |=> arb_sel == $past(i_wb_dat[19:17])) else $error("select not written");

  // Select untouched when its byte lane is off
  a_sel_lane_off: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && i_wb_we && !i_wb_sel[2] |=> $stable(arb_sel))
    else $error("select written without its lane");

  // Map write keeps class 0 whatever the data says
  a_map_write: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && i_wb_we && i_wb_adr == `VCR_OFF_CTL && i_wb_sel[0]
    |=> tc_map == ($past(i_wb_dat[7:0]) | 8'h01)) else $error("map write wrong");

  // Each writable class bit follows its own data bit
  for (genvar c = `VCR_TC_MAP_LSB + 1; c <= `VCR_TC_MAP_MSB; c++) begin : g_class_bit
    a_class_bit_write: assert property (@(posedge i_clock) disable iff (!i_resetn)
      i_clk_en && req && i_wb_we && i_wb_adr == `VCR_OFF_CTL && i_wb_sel[0]
      |=> tc_map[c] == $past(i_wb_dat[c])) else $error("class map bit not written");
  end

  // Live outputs track the stored fields
  a_live_outputs: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_traffic_class_map == tc_map && o_arb_select == arb_sel)
    else $error("live outputs out of step");

  // Arbiter is told when software broke the select rule
  a_valid_tracks_sel: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_arb_select_valid == (o_arb_select == vcr_pkg::VCR_ARB_HW_FIXED))
    else $error("select valid flag wrong");

  // Status word: every bit reads zero
  a_sts_read_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_STS
    |=> o_wb_dat == 32'h0) else $error("status word not zero");

  // Table status bit stays clear
  a_table_status_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr == `VCR_OFF_STS
    |=> !o_wb_dat[`VCR_TBL_STS_BIT])
    else $error("table status bit set");

  // Writes outside the control word change nothing
  a_ro_write_keep: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && i_wb_we && i_wb_adr != `VCR_OFF_CTL
    |=> $stable(tc_map) && $stable(arb_sel)) else $error("stray write took");

  // Reads never disturb the stored fields
  a_read_no_effect: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we |=> $stable(tc_map) && $stable(arb_sel))
    else $error("read changed state");

  // Unmapped reads return zero
  a_unmapped_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_clk_en && req && !i_wb_we && i_wb_adr != `VCR_OFF_CAP
    && i_wb_adr != `VCR_OFF_CTL && i_wb_adr != `VCR_OFF_STS
    |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");

  // Main scenarios
  c_ctl_write: cover property (@(posedge i_clock)
    req && i_wb_we && i_wb_adr == `VCR_OFF_CTL);
  c_cap_read: cover property (@(posedge i_clock)
    req && !i_wb_we && i_wb_adr == `VCR_OFF_CAP);
  c_sts_read: cover property (@(posedge i_clock)
    req && !i_wb_we && i_wb_adr == `VCR_OFF_STS);
  c_bad_select: cover property (@(posedge i_clock) !o_arb_select_valid);
  c_stalled_req: cover property (@(posedge i_clock) req && !i_clk_en);

endmodule : vcr_regs
`default_nettype wire

// ---- verification/test_vcr_regs.sv ----
// Purpose: Self-checking bench for the channel resource 0 register bank
// Assumes: Ack within the bounded wait of the bus task; writes answer with zero data
// Notes:   Rows run in order, so each row's live outputs follow from the rows above
`timescale 1ns/10ps
`default_nettype none
`include "vcr_cfg.svh"

module test_vcr_regs;
  typedef struct packed {
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
    logic [31:0] rd;
    logic [7:0]  map;
    logic [2:0]  asel;
  } vcr_row_t;

  logic                   i_clock;
  logic                   i_resetn;
  logic                   i_clk_en;
  logic                   i_wb_cyc;
  logic                   i_wb_stb;
  logic                   i_wb_we;
  logic [`VCR_ADDR_W-1:0] i_wb_adr;
  logic [3:0]             i_wb_sel;
  logic [31:0]            i_wb_dat;
  logic [31:0]            o_wb_dat;
  logic                   o_wb_ack;
  logic [7:0]             o_traffic_class_map;
  logic [2:0]             o_arb_select;
  logic                   o_arb_select_valid;
  int                     num_errors = 0;
  int                     num_checks = 0;

  // Accesses with the data and live outputs they should give
  vcr_row_t rows [17] = '{
    '{1'b0, 12'h210, 4'hf, 32'h0, 32'h00000001, 8'hff, 3'h0},
    '{1'b0, 12'h214, 4'hf, 32'h0, 32'h800000ff, 8'hff, 3'h0},
    '{1'b0, 12'h218, 4'hf, 32'h0, 32'h0, 8'hff, 3'h0},
    '{1'b1, 12'h214, 4'hf, 32'hffffffff, 32'h0, 8'hff, 3'h7},
    '{1'b0, 12'h214, 4'hf, 32'h0, 32'h800e00ff, 8'hff, 3'h7},
    '{1'b1, 12'h214, 4'hf, 32'h0, 32'h0, 8'h01, 3'h0},
    '{1'b0, 12'h214, 4'hf, 32'h0, 32'h80000001, 8'h01, 3'h0},
    '{1'b1, 12'h214, 4'hb, 32'h000200aa, 32'h0, 8'hab, 3'h0},
    '{1'b0, 12'h214, 4'hf, 32'h0, 32'h800000ab, 8'hab, 3'h0},
    '{1'b1, 12'h214, 4'h4, 32'h00040055, 32'h0, 8'hab, 3'h2},
    '{1'b0, 12'h214, 4'hf, 32'h0, 32'h800400ab, 8'hab, 3'h2},
    '{1'b1, 12'h210, 4'hf, 32'hffffffff, 32'h0, 8'hab, 3'h2},
    '{1'b0, 12'h210, 4'hf, 32'h0, 32'h00000001, 8'hab, 3'h2},
    '{1'b1, 12'h218, 4'hf, 32'hffffffff, 32'h0, 8'hab, 3'h2},
    '{1'b0, 12'h218, 4'hf, 32'h0, 32'h0, 8'hab, 3'h2},
    '{1'b0, 12'h21c, 4'hf, 32'h0, 32'h0, 8'hab, 3'h2},
    '{1'b1, 12'h21c, 4'hf, 32'hffffffff, 32'h0, 8'hab, 3'h2}
  };

  vcr_regs vcr_regs_i (
    .i_clock             (i_clock),
    .i_resetn            (i_resetn),
    .i_clk_en            (i_clk_en),
    .i_wb_cyc            (i_wb_cyc),
    .i_wb_stb            (i_wb_stb),
    .i_wb_we             (i_wb_we),
    .i_wb_adr            (i_wb_adr),
    .i_wb_sel            (i_wb_sel),
    .i_wb_dat            (i_wb_dat),
    .o_wb_dat            (o_wb_dat),
    .o_wb_ack            (o_wb_ack),
    .o_traffic_class_map (o_traffic_class_map),
    .o_arb_select        (o_arb_select),
    .o_arb_select_valid  (o_arb_select_valid)
  );

  // 200 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic wrap_up;
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp_word

  // Live map, select and valid packed as one value
  task automatic cmp_live(input logic [11:0] exp);
    cmp_word({20'h0, exp}, {20'h0, o_traffic_class_map, o_arb_select, o_arb_select_valid});
  endtask : cmp_live

  // One classic cycle; no ack latency assumed, a bounded wait instead
  task automatic bus(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                     input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_clock);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} <= {2'b11, we, adr, sel, dat};
    do begin
      @(posedge i_clock);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    rd = o_wb_dat;
    if (n >= 20)
      cmp_word(32'h1, 32'h0);
    {i_wb_cyc, i_wb_stb} <= 2'b00;
  endtask : bus

  // Watchdog, far beyond the fewer than a hundred cycles needed
  initial begin
    #(5 * 2000);
    num_errors++;
    wrap_up;
  end

  initial begin
    logic [31:0] rd;
    {i_resetn, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} = '0;
    i_clk_en = 1'b1;
    repeat (9) @(posedge i_clock);
    @(negedge i_clock);
    cmp_live(12'hff1);
    @(posedge i_clock);
    i_resetn <= 1'b1;
    foreach (rows[k]) begin
      bus(rows[k].we, rows[k].adr, rows[k].sel, rows[k].dat, rd);
      cmp_word(rows[k].rd, rd);
      @(negedge i_clock);
      cmp_live({rows[k].map, rows[k].asel, rows[k].asel == 3'h0});
    end
    // Enable held low must stall the answer
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    fork
      bus(1'b0, 12'h214, 4'hf, 32'h0, rd);
      begin
        repeat (4) @(posedge i_clock);
        cmp_word(32'h0, {31'h0, o_wb_ack});
        i_clk_en <= 1'b1;
      end
    join
    cmp_word(32'h800400ab, rd);
    // Second reset in mid-run restores the defaults
    @(posedge i_clock);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(negedge i_clock);
    cmp_live(12'hff1);
    bus(1'b0, 12'h214, 4'hf, 32'h0, rd);
    cmp_word(32'h800000ff, rd);
    wrap_up;
  end
endmodule : test_vcr_regs
`default_nettype wire
